// ===== rtl/lse_pkg.sv
// Package for the light sensor status and configuration register logic.
// Shared by the register bank, the host model and the bench; no other assumptions.
package lse_pkg;

    // Register offsets as seen on the internal register port
    localparam logic [7:0] ADDR_STATUS   = 8'h00;
    localparam logic [7:0] ADDR_MAIN_CFG = 8'h01;
    localparam logic [7:0] ADDR_RECV_CFG = 8'h02;

    // Reset values
    localparam logic [7:0] RST_STATUS   = 8'h04;
    localparam logic [7:0] RST_MAIN_CFG = 8'h24;
    localparam logic [7:0] RST_RECV_CFG = 8'h00;

    // Field positions
    localparam int POS_LIGHT_FLAG = 0;
    localparam int POS_POWER_FLAG = 2;
    localparam int POS_EVT_EN     = 0;
    localparam int POS_MODE_LO    = 2;
    localparam int POS_TRIM_SEL   = 5;
    localparam int POS_GAIN_LO    = 0;
    localparam int POS_TIME_LO    = 2;

    // Operating modes of the measurement path
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] MODE_G_MINUS_IR = 2'h1;
    localparam logic [1:0] MODE_GREEN = 2'h2;
    localparam logic [1:0] MODE_IR = 2'h3;

    // Integration times in ns and cycle counts at 100 MHz
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned INTEG_T0_NS   = 100000000;
    localparam int unsigned INTEG_T1_NS   = 25000000;
    localparam int unsigned INTEG_T2_NS   = 6250000;
    localparam int unsigned INTEG_T3_NS   = 1562500;
    localparam int unsigned INTEG_T0_CYC  = INTEG_T0_NS / CLK_PERIOD_NS;
    localparam int unsigned INTEG_T1_CYC  = INTEG_T1_NS / CLK_PERIOD_NS;
    localparam int unsigned INTEG_T2_CYC  = INTEG_T2_NS / CLK_PERIOD_NS;
    localparam int unsigned INTEG_T3_CYC  = INTEG_T3_NS / CLK_PERIOD_NS;

    // Result resolution in bits per integration time code
    localparam logic [3:0] RES_T0 = 4'hE;
    localparam logic [3:0] RES_T1 = 4'hC;
    localparam logic [3:0] RES_T2 = 4'hA;
    localparam logic [3:0] RES_T3 = 4'h8;

    // Consecutive triggers needed per persist code
    localparam logic [4:0] PERSIST_P0 = 5'h01;
    localparam logic [4:0] PERSIST_P1 = 5'h02;
    localparam logic [4:0] PERSIST_P2 = 5'h04;
    localparam logic [4:0] PERSIST_P3 = 5'h10;

    // One raw reading pair from the converters
    typedef struct packed {
        logic        valid;
        logic        overflow;
        logic [13:0] green;
        logic [13:0] ir;
    } lse_raw_t;

    // Register-port request from the serial interface engine
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lse_req_t;

endpackage : lse_pkg

// ===== rtl/lse_sticky_flag.sv
// Sticky flag cell: set by hardware events, cleared by software actions.
// Assumes set and clear are one-cycle, synchronous to clock.
`timescale 1ns/100ps
module lse_sticky_flag #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clock,   // System clock
    input  wire logic sys_rst, // Asynchronous reset, active high
    input  wire logic set,     // Event that sets the flag
    input  wire logic clr,     // Clear request
    output logic      flag_d,  // Next value, for same-cycle users
    output logic      flag_q   // Registered flag
);

    // Set wins over clear so an event in the clearing cycle survives
    always_comb
    begin
        flag_d = flag_q;
        if (clr)
            flag_d = 1'b0;
        if (set)
            flag_d = 1'b1;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            flag_q <= RST_VAL;
        else
            flag_q <= flag_d;
    end

endmodule : lse_sticky_flag

// ===== rtl/lse_regs.sv
// Status and configuration registers of the light sensor with event logic.
// Assumes a serial interface engine drives one-cycle read and write strobes,
// and that converter readings arrive as one-cycle valid pulses.
`timescale 1ns/100ps
module lse_regs #(
    parameter int unsigned INTEG_CYC_0 = lse_pkg::INTEG_T0_CYC, // Cycles for time code 00
    parameter int unsigned INTEG_CYC_1 = lse_pkg::INTEG_T1_CYC, // Cycles for time code 01
    parameter int unsigned INTEG_CYC_2 = lse_pkg::INTEG_T2_CYC, // Cycles for time code 10
    parameter int unsigned INTEG_CYC_3 = lse_pkg::INTEG_T3_CYC  // Cycles for time code 11
) (
    input  wire logic              clock,              // System clock, 100 MHz
    input  wire logic              sys_rst,            // Asynchronous reset, active high
    input  wire lse_pkg::lse_req_t req,                // Register read/write strobes
    output logic [7:0]             rdata_q,            // Read data, valid cycle after rd
    input  wire logic              supply_glitch,      // Supply glitch detected, pulse
    input  wire lse_pkg::lse_raw_t raw,                // Converter readings
    input  wire logic [13:0]       upper_thresh,       // Window upper limit
    input  wire logic [13:0]       lower_thresh,       // Window lower limit
    input  wire logic [1:0]        persist_count_select, // Persist code
    input  wire logic [6:0]        green_fine_gain,    // User green fine gain
    input  wire logic [8:0]        infrared_fine_gain, // User infrared fine gain
    input  wire logic [6:0]        green_factory_gain, // Factory green gain
    input  wire logic [8:0]        ir_factory_gain,    // Factory infrared gain
    output logic                   int_n_o_q,          // Interrupt pin output value
    output logic                   int_oe_n_q,         // Interrupt pin enable, low drives
    output logic                   thresh_default_q,   // Pulse: restore threshold defaults
    output logic [6:0]             green_gain_q,       // Applied green gain
    output logic [8:0]             ir_gain_q,          // Applied infrared gain
    output logic                   analog_en_q,        // Analog front end enable
    output logic [1:0]             light_gain_select_q, // Front-end gain code
    output logic [13:0]            result_q,           // Selected, masked result
    output logic                   result_valid_q,     // Pulse: result_q updated
    output logic                   conv_start_q,       // Pulse: start of integration
    output logic [3:0]             sar_bit_q,          // Bit being resolved
    output logic                   sar_busy_q          // Successive approximation active
);

    // Register state
    logic [7:0]  main_cfg_q, main_cfg_d;
    logic [7:0]  recv_cfg_q, recv_cfg_d;
    logic [7:0]  rdata_d;
    logic        thresh_default_d;
    logic        status_rd, main_wr;
    logic        pwr_flag_d, pwr_flag_q, evt_flag_d, evt_flag_q;
    logic        evt_set, evt_clr;
    logic        evt_en;
    logic [1:0]  mode, tsel;
    logic [3:0]  res_bits;
    logic [13:0] res_mask;
    logic [4:0]  persist_need;

    assign evt_en = main_cfg_q[lse_pkg::POS_EVT_EN];
    assign mode   = main_cfg_q[lse_pkg::POS_MODE_LO +: 2];
    assign tsel   = recv_cfg_q[lse_pkg::POS_TIME_LO +: 2];
    assign status_rd = req.rd && (req.addr == lse_pkg::ADDR_STATUS);
    assign main_wr   = req.wr && (req.addr == lse_pkg::ADDR_MAIN_CFG);

    // Resolution and persist lookups
    always_comb
    begin
        case (tsel)
            2'h0: res_bits = lse_pkg::RES_T0;
            2'h1: res_bits = lse_pkg::RES_T1;
            2'h2: res_bits = lse_pkg::RES_T2;
            2'h3: res_bits = lse_pkg::RES_T3;
            default: res_bits = lse_pkg::RES_T0;
        endcase
        res_mask = 14'(({15'h0000, 1'b1} << res_bits) - 16'h0001);
        case (persist_count_select)
            2'h0: persist_need = lse_pkg::PERSIST_P0;
            2'h1: persist_need = lse_pkg::PERSIST_P1;
            2'h2: persist_need = lse_pkg::PERSIST_P2;
            2'h3: persist_need = lse_pkg::PERSIST_P3;
            default: persist_need = lse_pkg::PERSIST_P0;
        endcase
    end

    // Register writes and read mux; reserved bits read as zero
    always_comb
    begin
        main_cfg_d = main_cfg_q;
        recv_cfg_d = recv_cfg_q;
        rdata_d    = rdata_q;
        thresh_default_d = supply_glitch;
        if (main_wr)
            main_cfg_d = req.wdata & 8'h2D;
        if (req.wr && (req.addr == lse_pkg::ADDR_RECV_CFG))
            recv_cfg_d = req.wdata & 8'h0F;
        if (req.rd)
        begin
            case (req.addr)
                lse_pkg::ADDR_STATUS:   rdata_d = {5'h00, pwr_flag_q, 1'b0, evt_flag_q};
                lse_pkg::ADDR_MAIN_CFG: rdata_d = main_cfg_q;
                lse_pkg::ADDR_RECV_CFG: rdata_d = recv_cfg_q;
                default:                rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            main_cfg_q       <= lse_pkg::RST_MAIN_CFG;
            recv_cfg_q       <= lse_pkg::RST_RECV_CFG;
            rdata_q          <= 8'h00;
            thresh_default_q <= 1'b0;
        end
        else
        begin
            main_cfg_q       <= main_cfg_d;
            recv_cfg_q       <= recv_cfg_d;
            rdata_q          <= rdata_d;
            thresh_default_q <= thresh_default_d;
        end
    end

    // Power flag: reset value set, glitch sets, only a status read clears
    lse_sticky_flag #(
        .RST_VAL (lse_pkg::RST_STATUS[lse_pkg::POS_POWER_FLAG])
    ) u_pwr_flag (
        .clock   (clock),
        .sys_rst (sys_rst),
        .set     (supply_glitch),
        .clr     (status_rd),
        .flag_d  (pwr_flag_d),
        .flag_q  (pwr_flag_q)
    );

    // Light flag: disable clears and holds it low, a read clears it
    assign evt_clr = status_rd || !evt_en || (main_wr && !req.wdata[lse_pkg::POS_EVT_EN]);
    lse_sticky_flag #(
        .RST_VAL (lse_pkg::RST_STATUS[lse_pkg::POS_LIGHT_FLAG])
    ) u_evt_flag (
        .clock   (clock),
        .sys_rst (sys_rst),
        .set     (evt_set && !(main_wr && !req.wdata[lse_pkg::POS_EVT_EN])),
        .clr     (evt_clr),
        .flag_d  (evt_flag_d),
        .flag_q  (evt_flag_q)
    );

    // Pin follows the next flag value so it changes with the flags
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            int_n_o_q  <= 1'b0;
            int_oe_n_q <= 1'b1;
        end
        else
        begin
            int_n_o_q  <= 1'b0;
            int_oe_n_q <= !(pwr_flag_d || evt_flag_d);
        end
    end

    // Result selection, masking and window comparison with persistence
    logic [13:0] sel_d, result_d;
    logic [14:0] diff;
    logic        result_valid_d, trig;
    logic [4:0]  persist_q, persist_d;

    always_comb
    begin
        diff = {1'b0, raw.green} - {1'b0, raw.ir};
        case (mode)
            lse_pkg::MODE_G_MINUS_IR: sel_d = diff[14] ? 14'h0000 : diff[13:0];
            lse_pkg::MODE_GREEN:      sel_d = raw.green;
            lse_pkg::MODE_IR:         sel_d = raw.ir;
            default:                  sel_d = 14'h0000;
        endcase
        result_valid_d = raw.valid && (mode != lse_pkg::MODE_SHUTDOWN);
        result_d       = result_valid_d ? (sel_d & res_mask) : result_q;
        trig      = (result_d > upper_thresh) || (result_d < lower_thresh);
        persist_d = persist_q;
        evt_set   = 1'b0;
        if (!evt_en)
            persist_d = 5'h00;
        else if (result_valid_d)
        begin
            if (raw.overflow)
                evt_set = 1'b1;
            if (trig)
            begin
                if (persist_q < persist_need)
                    persist_d = persist_q + 5'h01;
                if ((persist_q + 5'h01) >= persist_need)
                    evt_set = 1'b1;
            end
            else
                persist_d = 5'h00;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            result_q       <= 14'h0000;
            result_valid_q <= 1'b0;
            persist_q      <= 5'h00;
        end
        else
        begin
            result_q       <= result_d;
            result_valid_q <= result_valid_d;
            persist_q      <= persist_d;
        end
    end

    // Gain source, analog enable and front-end gain code
    logic [6:0] green_gain_d;
    logic [8:0] ir_gain_d;
    always_comb
    begin
        if (main_cfg_q[lse_pkg::POS_TRIM_SEL])
        begin
            green_gain_d = green_factory_gain;
            ir_gain_d    = ir_factory_gain;
        end
        else
        begin
            green_gain_d = green_fine_gain;
            ir_gain_d    = infrared_fine_gain;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            green_gain_q        <= 7'h00;
            ir_gain_q           <= 9'h000;
            analog_en_q         <= 1'b0;
            light_gain_select_q <= 2'h0;
        end
        else
        begin
            green_gain_q        <= green_gain_d;
            ir_gain_q           <= ir_gain_d;
            analog_en_q         <= (mode != lse_pkg::MODE_SHUTDOWN);
            light_gain_select_q <= recv_cfg_q[lse_pkg::POS_GAIN_LO +: 2];
        end
    end

    // Integration period divider and MSB-first bit sequencer
    logic [23:0] integ_cnt_q, integ_cnt_d, integ_last;
    logic        conv_start_d, sar_busy_d;
    logic [3:0]  sar_bit_d;
    always_comb
    begin
        case (tsel)
            2'h0: integ_last = 24'(INTEG_CYC_0 - 1);
            2'h1: integ_last = 24'(INTEG_CYC_1 - 1);
            2'h2: integ_last = 24'(INTEG_CYC_2 - 1);
            2'h3: integ_last = 24'(INTEG_CYC_3 - 1);
            default: integ_last = 24'(INTEG_CYC_0 - 1);
        endcase
        conv_start_d = 1'b0;
        integ_cnt_d  = integ_cnt_q + 24'h000001;
        if (mode == lse_pkg::MODE_SHUTDOWN)
            integ_cnt_d = 24'h000000;
        else if (integ_cnt_q >= integ_last)
        begin
            integ_cnt_d  = 24'h000000;
            conv_start_d = 1'b1;
        end
        sar_bit_d  = sar_bit_q;
        sar_busy_d = sar_busy_q;
        if (conv_start_d)
        begin
            sar_bit_d  = res_bits - 4'h1;
            sar_busy_d = 1'b1;
        end
        else if (sar_busy_q)
        begin
            if (sar_bit_q == 4'h0)
                sar_busy_d = 1'b0;
            else
                sar_bit_d = sar_bit_q - 4'h1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            integ_cnt_q  <= 24'h000000;
            conv_start_q <= 1'b0;
            sar_bit_q    <= 4'h0;
            sar_busy_q   <= 1'b0;
        end
        else
        begin
            integ_cnt_q  <= integ_cnt_d;
            conv_start_q <= conv_start_d;
            sar_bit_q    <= sar_bit_d;
            sar_busy_q   <= sar_busy_d;
        end
    end

    // Checks on the flag, pin and configuration behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_status_read;
        req.rd && (req.addr == lse_pkg::ADDR_STATUS);
    endsequence

    sequence s_read_then_data;
        s_status_read ##1 (rdata_q[lse_pkg::POS_POWER_FLAG] == $past(pwr_flag_q));
    endsequence

    property p_glitch_sets_power;
        supply_glitch |=> pwr_flag_q && thresh_default_q && !int_oe_n_q;
    endproperty
    a_glitch_sets_power: assert property (p_glitch_sets_power) else $error("glitch did not set power flag");

    property p_thresh_pulse;
        thresh_default_q |-> $past(supply_glitch);
    endproperty
    a_thresh_pulse: assert property (p_thresh_pulse) else $error("threshold restore without glitch");

    property p_power_only_read_clears;
        (pwr_flag_q && !status_rd) |=> pwr_flag_q;
    endproperty
    a_power_only_read_clears: assert property (p_power_only_read_clears) else $error("power flag lost");

    property p_read_clears;
        (s_status_read and !supply_glitch and !evt_set) |=> !pwr_flag_q && !evt_flag_q && int_oe_n_q;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("status read did not clear");

    property p_read_data;
        s_status_read |-> s_read_then_data;
    endproperty
    a_read_data: assert property (p_read_data) else $error("status read data wrong");

    property p_set_wins;
        (status_rd && supply_glitch) |=> pwr_flag_q;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost against clear");

    property p_disable_holds_low;
        !evt_en |=> !evt_flag_q;
    endproperty
    a_disable_holds_low: assert property (p_disable_holds_low) else $error("light flag set while disabled");

    // Pin leaves reset released while the power flag is already set, so skip that edge
    property p_pin_tracks_flags;
        !$past(sys_rst) |-> (int_oe_n_q == !(pwr_flag_q || evt_flag_q));
    endproperty
    a_pin_tracks_flags: assert property (p_pin_tracks_flags) else $error("pin disagrees with flags");

    property p_overflow_event;
        (evt_en && result_valid_d && raw.overflow && !main_wr) |=> evt_flag_q;
    endproperty
    a_overflow_event: assert property (p_overflow_event) else $error("overflow did not set light flag");

    property p_user_gain;
        !main_cfg_q[lse_pkg::POS_TRIM_SEL] |=> green_gain_q == $past(green_fine_gain);
    endproperty
    a_user_gain: assert property (p_user_gain) else $error("user gain not applied");

    property p_factory_gain;
        main_cfg_q[lse_pkg::POS_TRIM_SEL] |=> ir_gain_q == $past(ir_factory_gain);
    endproperty
    a_factory_gain: assert property (p_factory_gain) else $error("factory gain not applied");

    property p_shutdown;
        (mode == lse_pkg::MODE_SHUTDOWN) |=> !analog_en_q && !conv_start_q;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("analog active in shutdown");

    property p_msb_first;
        conv_start_q |-> sar_busy_q && (sar_bit_q == $past(res_bits) - 4'h1);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("conversion not started at top bit");

endmodule : lse_regs

// ===== sim/lse_host_model.sv
// Host side of the register port: single-byte strobed reads and writes.
// Assumes one calling process; each access leaves one idle edge behind it.
`timescale 1ns/100ps
module lse_host_model (
    input  wire logic        clock, // System clock
    output lse_pkg::lse_req_t req   // Strobed request to the register bank
);
    initial req = '0;

    // Strobe stands for exactly one edge, then the port goes quiet again
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clock);
        req <= '0;
    endtask : access

    // Callers only ever pass legal mode codes; the field cannot hold reserved ones
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        access(1'b1, a, d);
    endtask : write_reg
endmodule : lse_host_model

// ===== sim/lse_regs_bench.sv
// Self-checking bench for the status and configuration registers.
// Assumes the host model drives the register port; read data checked from a queue.
`timescale 1ns/100ps
module lse_regs_bench;
    logic              clock = 1'b0;
    logic              sys_rst = 1'b1;
    lse_pkg::lse_req_t req;
    lse_pkg::lse_raw_t raw = '0;
    logic              supply_glitch = 1'b0;
    logic [6:0]        g_user = 7'h00, g_fact = 7'h00, green_gain_q;
    logic [8:0]        ir_user = 9'h000, ir_fact = 9'h000, ir_gain_q;
    logic [7:0]        rdata_q;
    logic [1:0]        light_gain_select_q;
    logic              int_n_o_q, int_oe_n_q, thresh_default_q, analog_en_q;
    logic [7:0]        exp_q[$];
    logic [13:0]       res_q[$];
    logic [13:0]       result_q, val;
    logic [13:0]       up_th = 14'h0100, lo_th = 14'h0000;
    logic [1:0]        pst = 2'h1;
    logic [3:0]        sar_bit_q;
    logic              result_valid_q, conv_q, sar_busy_q;
    logic              rd_seen = 1'b0;
    int                errors = 0;
    int                comparisons = 0;
    wire               int_pin = int_oe_n_q ? 1'b1 : int_n_o_q; // External pull-up when released

    always #5 clock = ~clock;

    lse_host_model host (.clock(clock), .req(req));

    // Short integration counts keep the run brief
    lse_regs #(.INTEG_CYC_0(40), .INTEG_CYC_1(20), .INTEG_CYC_2(10), .INTEG_CYC_3(8)) uut (
        .clock(clock), .sys_rst(sys_rst), .req(req), .rdata_q(rdata_q), .supply_glitch(supply_glitch),
        .raw(raw), .upper_thresh(up_th), .lower_thresh(lo_th), .persist_count_select(pst),
        .green_fine_gain(g_user), .infrared_fine_gain(ir_user), .green_factory_gain(g_fact),
        .ir_factory_gain(ir_fact), .int_n_o_q(int_n_o_q), .int_oe_n_q(int_oe_n_q),
        .thresh_default_q(thresh_default_q), .green_gain_q(green_gain_q), .ir_gain_q(ir_gain_q),
        .analog_en_q(analog_en_q), .light_gain_select_q(light_gain_select_q), .result_q(result_q),
        .result_valid_q(result_valid_q), .conv_start_q(conv_q), .sar_bit_q(sar_bit_q), .sar_busy_q(sar_busy_q));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    // Read with its expected byte noted first, so the watcher can pair them
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.access(1'b0, a, 8'h00);
    endtask : rd

    // One converter reading; its expected result is noted for the result watcher
    task automatic sample(input logic ovf, input logic [13:0] g, input logic [13:0] r, input logic [13:0] e);
        res_q.push_back(e);
        @(posedge clock);
        raw <= '{valid: 1'b1, overflow: ovf, green: g, ir: r};
        @(posedge clock);
        raw.valid <= 1'b0;
        repeat (2) @(posedge clock);
        @(negedge clock);
    endtask : sample

    // Read data stands the cycle after the strobe edge; look at it mid-cycle
    always @(posedge clock) rd_seen <= req.rd;
    always @(negedge clock)
    begin
        if (rd_seen === 1'b1 && exp_q.size() == 0)
            check(16'h0001, 16'h0000, "read without expectation");
        else if (rd_seen === 1'b1)
            check(16'(rdata_q), 16'(exp_q.pop_front()), "read data");
    end

    // Results stand one cycle after the valid edge; each one must have been noted
    always @(negedge clock)
    begin
        if (result_valid_q === 1'b1 && res_q.size() == 0)
            check(16'h0001, 16'h0000, "result without expectation");
        else if (result_valid_q === 1'b1)
            check(16'(result_q), 16'(res_q.pop_front()), "result");
    end

    // Waits for an integration start at 8-bit resolution, then counts cycles to the next
    task automatic period(input logic [15:0] e);
        int n;
        n = 0;
        do
        begin
            @(negedge clock);
            n++;
        end
        while (conv_q !== 1'b1 && n < 100);
        check(16'({conv_q, sar_busy_q, sar_bit_q}), 16'h0037, "top bit first");
        n = 0;
        do
        begin
            @(negedge clock);
            n++;
        end
        while (conv_q !== 1'b1 && n < 100);
        check(16'(n), e, "integration period");
    endtask : period

    // Watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (3000) @(posedge clock);
        check(16'h0001, 16'h0000, "timeout");
        close_out();
    end

    initial
    begin
        void'($urandom(32'h9ab21f1a));
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        rd(8'h00, 8'h04);
        rd(8'h00, 8'h00);
        rd(8'h01, 8'h24);
        rd(8'h02, 8'h00);
        $display("test reset values done");
        host.write_reg(8'h01, 8'hFF);
        rd(8'h01, 8'h2D);
        host.write_reg(8'h02, 8'hF6);
        rd(8'h02, 8'h06);
        @(negedge clock);
        check(16'(light_gain_select_q), 16'h0002, "gain code");
        $display("test masks done");
        @(posedge clock);
        g_user <= 7'($urandom);
        g_fact <= 7'($urandom);
        ir_user <= 9'($urandom);
        ir_fact <= 9'($urandom);
        host.write_reg(8'h01, 8'h29);
        @(negedge clock);
        check(16'(green_gain_q), 16'(g_fact), "factory green");
        check(16'(ir_gain_q), 16'(ir_fact), "factory ir");
        host.write_reg(8'h01, 8'h01);
        @(posedge clock);
        @(negedge clock);
        check(16'(analog_en_q), 16'h0000, "shutdown");
        check(16'(green_gain_q), 16'(g_user), "user green");
        check(16'(ir_gain_q), 16'(ir_user), "user ir");
        host.write_reg(8'h01, 8'h09);
        rd(8'h01, 8'h09);
        $display("test gains done");
        // Persist of two: a miss between triggers restarts the count
        val = 14'h0200 + 14'(9'($urandom));
        sample(1'b0, val, 14'h0000, val);
        sample(1'b0, 14'h0080, 14'h0000, 14'h0080);
        sample(1'b0, 14'h0200, 14'h0000, 14'h0200);
        check(16'(int_pin), 16'h0001, "pin after one trigger");
        sample(1'b0, 14'h3FFF, 14'h0000, 14'h0FFF);
        check(16'(int_pin), 16'h0000, "pin after two triggers");
        rd(8'h00, 8'h01);
        @(negedge clock);
        check(16'(int_pin), 16'h0001, "pin after status read");
        sample(1'b1, 14'h0080, 14'h0000, 14'h0080);
        check(16'(int_pin), 16'h0000, "pin after overflow");
        host.write_reg(8'h01, 8'h08);
        @(negedge clock);
        check(16'(int_pin), 16'h0001, "pin after disable");
        sample(1'b0, 14'h3FFF, 14'h0000, 14'h0FFF);
        sample(1'b0, 14'h3FFF, 14'h0000, 14'h0FFF);
        rd(8'h00, 8'h00);
        $display("test events done");
        // Glitch lands in the same cycle as a status read: the set must survive
        fork
            rd(8'h00, 8'h00);
            begin
                @(posedge clock);
                supply_glitch <= 1'b1;
                @(posedge clock);
                supply_glitch <= 1'b0;
            end
        join
        @(negedge clock);
        check(16'(thresh_default_q), 16'h0001, "threshold restore");
        @(negedge clock);
        check(16'(int_pin), 16'h0000, "pin after glitch");
        rd(8'h00, 8'h04);
        rd(8'h01, 8'h08);
        $display("test power event done");
        // Difference and infrared modes at 8-bit resolution, then a low-side event
        host.write_reg(8'h02, 8'h0C);
        host.write_reg(8'h01, 8'h04);
        period(16'h0008);
        sample(1'b0, 14'h0150, 14'h0030, 14'h0020);
        sample(1'b0, 14'h0030, 14'h0150, 14'h0000);
        @(posedge clock);
        pst   <= 2'h0;
        lo_th <= 14'h0100;
        host.write_reg(8'h01, 8'h0D);
        sample(1'b0, 14'h0010, 14'h01AB, 14'h00AB);
        check(16'(int_pin), 16'h0000, "pin after low reading");
        rd(8'h00, 8'h01);
        host.write_reg(8'h01, 8'h00);
        @(posedge clock);
        raw <= '{valid: 1'b1, overflow: 1'b0, green: 14'h0010, ir: 14'h0010};
        @(posedge clock);
        raw.valid <= 1'b0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        check(16'(analog_en_q), 16'h0000, "shutdown ignores readings");
        $display("test modes done");
        check(16'(exp_q.size() + res_q.size()), 16'h0000, "unanswered notes");
        close_out();
    end
endmodule : lse_regs_bench
